// ### include/sysrc_map.vh
`ifndef SYSRC_MAP_VH
`define SYSRC_MAP_VH
// ----------------------------------------
// source bit positions
// ----------------------------------------
`define SYSRC_NSRC 6
`define SYSRC_SRC_POWERON 0
`define SYSRC_SRC_PIN 1
`define SYSRC_SRC_WDOG 2
`define SYSRC_SRC_BROWNOUT 3
`define SYSRC_SRC_DEBUG 4
`define SYSRC_SRC_SOFT 5
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SYSRC_ADDR_STATUS 4'h0
`define SYSRC_ADDR_CTRL 4'h1
`define SYSRC_ADDR_IRQ_STAT 4'h2
`define SYSRC_ADDR_IRQ_EN 4'h3
`define SYSRC_ADDR_IRQ_CLR 4'h4
`define SYSRC_ADDR_SEQ 4'h5
// ----------------------------------------
// control fields
// ----------------------------------------
`define SYSRC_CTRL_SOFTRST 0
`define SYSRC_CTRL_BOOTVEC 1
`define SYSRC_CTRL_RESET 8'h00
`define SYSRC_SOFT_KEY 8'ha5
// ----------------------------------------
// timing counts in cycles
// ----------------------------------------
`define SYSRC_CNT_DELAY 16'h0040
`define SYSRC_CNT_OSCUP 16'h0100
`define SYSRC_CNT_OSCCAL 16'h0080
// ----------------------------------------
// vectors
// ----------------------------------------
`define SYSRC_VEC_DEFAULT 16'h0000
`define SYSRC_VEC_BOOT 16'hf000
`endif

// ### rtl/sysrc_reset_ctrl.v
// Contract
// RULE1: six request inputs are accepted: power-on, pin, watchdog, brownout, debug port and software.
// RULE2: any active request resets at once and reset holds until every request is gone.
// RULE3: entering reset releases every pin drive at once, without a clock edge.
// RULE4: during reset the core reset is held, the fetch address is the reset vector and I/O registers are held at init.
// RULE5: working memory is not cleared, only accesses are blocked during reset.
// RULE6: the vector is address 0 unless the boot option moves it to the boot section start.
// RULE7: reset entry is asynchronous and needs no running clock.
// RULE8: software can request a full reset that is handled like any other source.
// RULE9: after release the sequence runs counter delay, oscillator startup then calibration, in order.
// RULE10: a request during the release stages abandons the sequence, which restarts when all are gone.
// RULE11: one sticky flag per source records resets, cleared only by power-on. Here the bus reset rst_n also clears them.
// RULE12: the power-on indication starts the sequence when supply rises and forces reset when it falls.
// RULE13: the three stage lengths are parameters.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "sysrc_map.vh"
module sysrc_reset_ctrl #(
    parameter [15:0] DELAY_CYCLES = `SYSRC_CNT_DELAY, // RULE13
    parameter [15:0] OSCUP_CYCLES = `SYSRC_CNT_OSCUP,
    parameter [15:0] OSCCAL_CYCLES = `SYSRC_CNT_OSCCAL
) (
    // clock and bus reset
    input wire clk,
    input wire rst_n,
    // reset requests, active high
    input wire powerOnLow,
    input wire extResetPin,
    input wire watchdogReq,
    input wire brownoutReq,
    input wire debugPortReset,
    // register port
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdData,
    // oscillator
    input wire oscReady,
    input wire oscCalDone,
    output wire oscEnable,
    output wire oscCalibrate,
    // core and pins
    output wire coreReset,
    output wire pinDriveEnable,
    output wire sramAccessEnable,
    output reg [15:0] resetVector,
    // interrupt
    output wire irq
);
// ----------------------------------------
// states
// ----------------------------------------
localparam [4:0] ST_HOLD = 5'h01;
localparam [4:0] ST_DELAY = 5'h02;
localparam [4:0] ST_OSCUP = 5'h04;
localparam [4:0] ST_OSCCAL = 5'h08;
localparam [4:0] ST_RUN = 5'h10;

function sync3Agree;
    input [2:0] s;
    begin
        sync3Agree = s[1] & s[2];
    end
endfunction

// register address match, shared by write and read decode
function regHit;
    input [3:0] addr;
    input [3:0] target;
    begin
        regHit = (addr == target);
    end
endfunction

// a release stage ends once its count is reached and its input is ready
function stageDone;
    input [15:0] count;
    input [15:0] limit;
    input ready;
    begin
        stageDone = (count >= limit) && ready;
    end
endfunction

// ----------------------------------------
// request gathering
// ----------------------------------------
reg softReq;
reg [5:0] seenSrc;
wire [5:0] reqVec;
wire anyReq;
assign reqVec = {softReq, debugPortReset, brownoutReq, watchdogReq,
    extResetPin, powerOnLow}; // RULE1 RULE12
assign anyReq = |reqVec;

// ----------------------------------------
// pin request filter for the status flags
// ----------------------------------------
// reset entry uses the raw pins; the flags only see a
// level once the second and third stages agree on it
wire [4:0] pinReq;
reg [4:0] pinSync1;
reg [4:0] pinSync2;
reg [4:0] pinSync3;
reg [4:0] pinStable;
reg [4:0] next_pinStable;
wire [5:0] seenReq;
assign pinReq = {debugPortReset, brownoutReq, watchdogReq, extResetPin,
    powerOnLow};

always @* begin
    next_pinStable = (pinSync2 & pinSync3)
        | (pinStable & (pinSync2 | pinSync3));
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        pinSync1 <= 5'h00;
        pinSync2 <= 5'h00;
        pinSync3 <= 5'h00;
        pinStable <= 5'h00;
    end else begin
        pinSync1 <= pinReq;
        pinSync2 <= pinSync1;
        pinSync3 <= pinSync2;
        pinStable <= next_pinStable;
    end
end
assign seenReq = {softReq, pinStable};

// async reset of the sequencer from any request
wire seqRst_n;
assign seqRst_n = rst_n & ~anyReq; // RULE7 RULE2

reg [4:0] state;
reg [4:0] next_state;
reg [15:0] cnt;
reg [15:0] next_cnt;
reg [2:0] oscReadySync;
reg [2:0] oscCalSync;
reg bootSel;

// ----------------------------------------
// release sequence
// ----------------------------------------
always @* begin
    next_state = state;
    case (state)
        ST_HOLD: begin
            next_state = ST_DELAY;
        end
        ST_DELAY: begin
            if (stageDone(cnt, DELAY_CYCLES, 1'b1))
                next_state = ST_OSCUP;
        end
        ST_OSCUP: begin
            if (stageDone(cnt, OSCUP_CYCLES, sync3Agree(oscReadySync)))
                next_state = ST_OSCCAL;
        end
        ST_OSCCAL: begin
            if (stageDone(cnt, OSCCAL_CYCLES, sync3Agree(oscCalSync)))
                next_state = ST_RUN;
        end
        ST_RUN: begin
            next_state = ST_RUN;
        end
        default: begin
            next_state = ST_HOLD;
        end
    endcase
end

// stage counter restarts at every state change
always @* begin
    next_cnt = cnt;
    if (next_state != state)
        next_cnt = 16'h0000;
    else if (cnt != 16'hffff)
        next_cnt = cnt + 16'h0001;
end

// the request clears the state machine, so any mid-sequence request
// starts over from the hold state
always @(posedge clk or negedge seqRst_n) begin
    if (!seqRst_n) begin
        state <= ST_HOLD; // RULE10
        cnt <= 16'h0000;
        oscReadySync <= 3'h0;
        oscCalSync <= 3'h0;
    end else begin
        oscReadySync <= {oscReadySync[1:0], oscReady};
        oscCalSync <= {oscCalSync[1:0], oscCalDone};
        state <= next_state; // RULE9
        cnt <= next_cnt;
    end
end

wire running;
assign running = state[4] & ~anyReq;
assign coreReset = ~running; // RULE2 RULE4
assign pinDriveEnable = running; // RULE3
assign sramAccessEnable = running; // RULE5
assign oscEnable = state[2] | state[3] | state[4];
assign oscCalibrate = state[3];

// ----------------------------------------
// status flags, cleared at power-on and by the bus reset rst_n
// ----------------------------------------
// seenSrc lives on clk, so it records sources sampled while clk runs;
// the power-on source also acts as the flag clear
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        seenSrc <= 6'h00;
    end else if (pinStable[`SYSRC_SRC_POWERON]) begin
        seenSrc <= 6'h01; // RULE11 RULE12
    end else begin
        seenSrc <= seenSrc | seenReq; // RULE11
    end
end

// ----------------------------------------
// control register and soft reset
// ----------------------------------------
reg [5:0] irqStat;
reg [5:0] irqEn;
reg [5:0] seenPrev;
wire [5:0] newSrc;
assign newSrc = seenSrc & ~seenPrev;
wire wrCtrl;
wire wrIrqEn;
wire wrIrqClr;
assign wrCtrl = regWr & regHit(regAddr, `SYSRC_ADDR_CTRL);
assign wrIrqEn = regWr & regHit(regAddr, `SYSRC_ADDR_IRQ_EN);
assign wrIrqClr = regWr & regHit(regAddr, `SYSRC_ADDR_IRQ_CLR);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        softReq <= 1'b0;
        bootSel <= 1'b0;
    end else begin
        if (wrCtrl) begin
            bootSel <= regWrData[`SYSRC_CTRL_BOOTVEC];
            if (regWrData[`SYSRC_CTRL_SOFTRST] && running)
                softReq <= 1'b1; // RULE8
        end else if (softReq && state[0]) begin
            softReq <= 1'b0;
        end
    end
end

// vector register follows the boot option bit
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        resetVector <= `SYSRC_VEC_DEFAULT;
    end else if (wrCtrl) begin
        if (regWrData[`SYSRC_CTRL_BOOTVEC])
            resetVector <= `SYSRC_VEC_BOOT; // RULE6
        else
            resetVector <= `SYSRC_VEC_DEFAULT; // RULE6
    end
end

// ----------------------------------------
// interrupt
// ----------------------------------------
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        irqStat <= 6'h00;
        irqEn <= 6'h00;
        seenPrev <= 6'h00;
    end else begin
        seenPrev <= seenSrc;
        if (wrIrqEn)
            irqEn <= regWrData[5:0];
        if (wrIrqClr)
            irqStat <= (irqStat & ~regWrData[5:0]) | newSrc;
        else
            irqStat <= irqStat | newSrc;
    end
end
assign irq = |(irqStat & irqEn);

// ----------------------------------------
// read port
// ----------------------------------------
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        regRdData <= 8'h00;
    end else if (regRd) begin
        if (regHit(regAddr, `SYSRC_ADDR_STATUS))
            regRdData <= {2'h0, seenSrc};
        else if (regHit(regAddr, `SYSRC_ADDR_CTRL))
            regRdData <= {6'h00, bootSel, softReq};
        else if (regHit(regAddr, `SYSRC_ADDR_IRQ_STAT))
            regRdData <= {2'h0, irqStat};
        else if (regHit(regAddr, `SYSRC_ADDR_IRQ_EN))
            regRdData <= {2'h0, irqEn};
        else if (regHit(regAddr, `SYSRC_ADDR_SEQ))
            regRdData <= {3'h0, state};
        else
            regRdData <= 8'h00;
    end else begin
        regRdData <= 8'h00;
    end
end

endmodule // sysrc_reset_ctrl

// ### verif/sysrc_monitor.sv
`timescale 1ns/1ns
module sysrc_monitor (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // requests and outputs
    input wire powerOnLow,
    input wire extResetPin,
    input wire watchdogReq,
    input wire brownoutReq,
    input wire debugPortReset,
    input wire oscEnable,
    input wire oscCalibrate,
    input wire coreReset,
    input wire pinDriveEnable,
    input wire sramAccessEnable,
    input wire [15:0] resetVector
);
    wire req = powerOnLow | extResetPin | watchdogReq | brownoutReq
        | debugPortReset;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence heldIn; coreReset [*3]; endsequence
    sequence calLast; $past(oscCalibrate); endsequence
    AST_REQ_HOLD: assert property (req |-> coreReset)
        else $error("request without core reset");
    AST_PIN_OFF: assert property (req |-> !pinDriveEnable)
        else $error("pins driven during request");
    AST_SRAM: assert property (sramAccessEnable == pinDriveEnable)
        else $error("memory access outside run");
    AST_VEC: assert property (resetVector == 16'h0000
        || resetVector == 16'hf000)
        else $error("bad reset vector");
    AST_CAL_ON: assert property (oscCalibrate |-> oscEnable && coreReset)
        else $error("calibration outside startup");
    AST_ABORT: assert property (req |=> !oscEnable)
        else $error("sequence kept running");
    AST_DELAY: assert property ($fell(req) |-> heldIn)
        else $error("release without delay");
    AST_ORDER: assert property ($fell(coreReset) |-> calLast)
        else $error("release without calibration");
endmodule // sysrc_monitor
bind sysrc_reset_ctrl sysrc_monitor mon (.clk, .rst_n, .powerOnLow,
    .extResetPin, .watchdogReq, .brownoutReq, .debugPortReset,
    .oscEnable, .oscCalibrate, .coreReset, .pinDriveEnable,
    .sramAccessEnable, .resetVector);

// ### verif/sysrc_osc_model.sv
`timescale 1ns/1ns
module sysrc_osc_model #(parameter int UP = 6, parameter int CAL = 3) (
    input wire clk,
    input wire oscEnable,
    input wire oscCalibrate,
    output wire oscReady,
    output wire oscCalDone
);
    int nUp = 0;
    int nCal = 0;
    always @(posedge clk) begin
        nUp <= oscEnable ? nUp + 1 : 0;
        nCal <= oscCalibrate ? nCal + 1 : 0;
    end
    assign oscReady = oscEnable && nUp >= UP;
    assign oscCalDone = oscCalibrate && nCal >= CAL;
endmodule // sysrc_osc_model

// ### verif/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clk = 0, rst_n = 0, regWr = 0, regRd = 0;
    logic [4:0] src = 5'h01;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    wire [7:0] regRdData;
    wire [15:0] resetVector;
    wire oscReady, oscCalDone, oscEnable, oscCalibrate, coreReset;
    wire pinDriveEnable, sramAccessEnable, irq;
    int failures = 0, checkCount = 0, i;
    sysrc_reset_ctrl #(.DELAY_CYCLES(16'h0004), .OSCUP_CYCLES(16'h0004),
        .OSCCAL_CYCLES(16'h0004)) uut (.clk, .rst_n, .powerOnLow(src[0]),
        .extResetPin(src[1]), .watchdogReq(src[2]), .brownoutReq(src[3]),
        .debugPortReset(src[4]), .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .oscReady, .oscCalDone, .oscEnable, .oscCalibrate,
        .coreReset, .pinDriveEnable, .sramAccessEnable, .resetVector, .irq);
    sysrc_osc_model osc (.clk, .oscEnable, .oscCalibrate, .oscReady,
        .oscCalDone);
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task report_and_stop;
        $display("checks %0d errors %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        @(posedge clk); regWr <= 1; regAddr <= a; regWrData <= d;
        @(posedge clk); regWr <= 0;
        #1;
    endtask
    task rd(input [3:0] a, input [7:0] e);
        @(posedge clk); regRd <= 1; regAddr <= a;
        @(posedge clk); regRd <= 0;
        #1 chk(regRdData, e);
    endtask
    task settle;
        for (i = 0; i < 400 && coreReset !== 0; i++) begin
            @(posedge clk);
            #1;
        end
        chk(coreReset, 0);
        if (coreReset !== 0) report_and_stop;
    endtask
    task hit(input int b);
        @(posedge clk); src[b] <= 1;
        #1 chk({pinDriveEnable, coreReset}, 2'b01);
        repeat (3) @(posedge clk);
        src[b] <= 0;
        settle;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_power;
        repeat (4) @(posedge clk);
        src[0] <= 0;
        settle;
        rd(4'h5, 8'h10);
        rd(4'h0, 8'h01);
        chk(resetVector, 16'h0000);
        rd(4'hf, 8'h00);
    endtask
    task t_irq;
        wr(4'h3, 8'h00);
        hit(1);
        rd(4'h0, 8'h03);
        chk(irq, 0);
        wr(4'h3, 8'hff);
        chk(irq, 1);
        wr(4'h4, 8'hff);
        chk(irq, 0);
    endtask
    task t_sources;
        for (int b = 2; b < 5; b++) begin
            hit(b);
            rd(4'h0, 8'((1 << (b + 1)) - 1));
            chk(irq, 1);
            wr(4'h4, 8'hff);
        end
    endtask
    task t_soft;
        wr(4'h1, 8'h01);
        chk(coreReset, 1);
        settle;
        rd(4'h0, 8'h3f);
        wr(4'h1, 8'h02);
        chk(resetVector, 16'hf000);
    endtask
    task t_abort;
        @(posedge clk); src[2] <= 1;
        @(posedge clk); src[2] <= 0;
        for (i = 0; i < 100 && oscEnable !== 1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(oscEnable, 1);
        @(posedge clk); src[1] <= 1;
        #1 chk(coreReset, 1);
        @(posedge clk); src[1] <= 0;
        #1 chk(oscEnable, 0);
        settle;
    endtask
    task t_por;
        hit(0);
        rd(4'h0, 8'h01);
    endtask
    initial forever #4 clk = ~clk;
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        t_power;
        t_irq;
        t_sources;
        t_soft;
        t_abort;
        t_por;
        report_and_stop;
    end
endmodule // testbench
